// file: common/lin_pkg.sv
// Constants shared by the LIN transceiver control block and its wake-up detector.
// Assumes a 50 MHz system clock and the plain register port of the block.
package lin_pkg;
  localparam int CLK_PERIOD_NS = 20;

  // Minimum dominant time of a bus wake-up, least time so rounded up
  localparam int WAKE_MIN_US     = 70;
  localparam int WAKE_MIN_CYCLES = (WAKE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W      = $clog2(WAKE_MIN_CYCLES + 1);

  // Transmit-dominant timeout; figure is a plain default
  localparam int TXDOM_US     = 5000;
  localparam int TXDOM_CYCLES = (TXDOM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h10;

  // Control register fields
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_RATE_LSB  = 1;
  localparam int CTRL_WAKEN_BIT = 3;

  // Status register fields
  localparam int ST_MODE_BIT  = 0;
  localparam int ST_TOUT_BIT  = 1;
  localparam int ST_UV_BIT    = 2;
  localparam int ST_OT_BIT    = 3;
  localparam int ST_RX_BIT    = 4;
  localparam int ST_DRIVE_BIT = 5;

  // Interrupt event bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_TOUT_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_UV_BIT   = 2;
  localparam int IRQ_OT_BIT   = 3;

  // Input synchroniser bit order
  localparam int SYNC_W      = 4;
  localparam int SYN_TXD_BIT = 0;
  localparam int SYN_BUS_BIT = 1;
  localparam int SYN_UV_BIT  = 2;
  localparam int SYN_OT_BIT  = 3;

  typedef enum logic [1:0] {
    RATE_20K  = 2'h0,
    RATE_10K  = 2'h1,
    RATE_FAST = 2'h2
  } rate_t;

  localparam logic       CTRL_MODE_RST  = 1'b0;
  localparam rate_t      CTRL_RATE_RST  = RATE_20K;
  localparam logic       CTRL_WAKEN_RST = 1'b1;
  localparam logic [3:0] IRQ_EN_RST     = 4'h0;
endpackage : lin_pkg

// file: common/lin_wake_if.sv
// Carrier between the transceiver control and its bus wake-up detector.
// Both ends run on the same system clock.
`timescale 1ns/1ns
interface lin_wake_if;
  logic enable;
  logic busDominant;
  logic wakePulse;

  modport ctrl (output enable, output busDominant, input wakePulse);
  modport det  (input enable, input busDominant, output wakePulse);
endinterface : lin_wake_if

// file: rtl/lin_transceiver_control.sv
// LIN transceiver control: modes, transmit gating, receive path, wake-up,
// register port and interrupt. Assumes pin and analog-flag inputs are
// asynchronous; device mode inputs come from logic on the same clock.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

module lin_transceiver_control
#(
  parameter int TXDOM_CYCLES = lin_pkg::TXDOM_CYCLES
)
(
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [lin_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [lin_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [lin_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                        normalMode,
  input  wire logic                        lowpowerRegulatorOn,
  input  wire logic                        lowpowerRegulatorOff,
  input  wire logic                        secondLinTxInput,
  output logic                             secondLinRxOutput,
  input  wire logic                        secondBusPinIn,
  output logic                             secondBusPinOut,
  output logic                             secondBusPinOe,
  input  wire logic                        supplyUndervoltage,
  input  wire logic                        driverOvertemp,
  output logic                             weakPullupEn,
  output logic                             normalPullupEn,
  output logic      [1:0]                  slewSelect,
  output logic                             wakeEvent,
  output logic                             wakeIntPulse,
  output logic                             regulatorRestart,
  output logic                             irq
);
  localparam int TX_CNT_W = $clog2(TXDOM_CYCLES + 1);
  localparam logic [TX_CNT_W-1:0] TX_LIMIT = TX_CNT_W'(TXDOM_CYCLES);

  typedef struct packed {
    logic [lin_pkg::SYNC_W-1:0]  sync1;
    logic [lin_pkg::SYNC_W-1:0]  sync2;
    logic                        ctrlMode;
    lin_pkg::rate_t              rate;
    logic                        wakeEn;
    logic [lin_pkg::IRQ_W-1:0]   irqStat;
    logic [lin_pkg::IRQ_W-1:0]   irqEn;
    logic [TX_CNT_W-1:0]         txCount;
    logic                        timeout;
    logic                        prevTxd;
    logic                        prevUv;
    logic                        prevOt;
    logic [lin_pkg::DATA_W-1:0]  rdata;
    logic                        busOe;
    logic                        rxd;
    logic                        weakPu;
    logic                        normPu;
    logic                        wakeEvt;
    logic                        intPulse;
    logic                        regRestart;
    logic                        irqOut;
  } ctl_t;

  ctl_t st_reg;
  ctl_t st_next;

  lin_wake_if wakeBus ();

  lin_wake_detect wakeDetect
  (
    .clock  (clock),
    .resetn (resetn),
    .wk     (wakeBus.det)
  );

  logic txdHigh;
  logic busHigh;
  logic underVolt;
  logic overTemp;
  logic active;

  assign txdHigh   = st_reg.sync2[lin_pkg::SYN_TXD_BIT];
  assign busHigh   = st_reg.sync2[lin_pkg::SYN_BUS_BIT];
  assign underVolt = st_reg.sync2[lin_pkg::SYN_UV_BIT];
  assign overTemp  = st_reg.sync2[lin_pkg::SYN_OT_BIT];
  // Only transmit/receive mode while the device is in Normal mode
  assign active    = normalMode && st_reg.ctrlMode;

  // Wake monitoring runs in sleep regardless of device mode
  assign wakeBus.enable      = !st_reg.ctrlMode && st_reg.wakeEn;
  assign wakeBus.busDominant = !busHigh;

  always_comb
  begin
    logic [lin_pkg::IRQ_W-1:0] events;
    logic [lin_pkg::IRQ_W-1:0] clr;
    logic                      wrCtrl;
    events  = '0;
    clr     = '0;
    wrCtrl  = regWrite && (regAddr == lin_pkg::CTRL_OFS);
    st_next = st_reg;

    st_next.sync1 = {driverOvertemp, supplyUndervoltage, secondBusPinIn, secondLinTxInput};
    st_next.sync2 = st_reg.sync1;
    st_next.prevTxd = txdHigh;
    st_next.prevUv  = underVolt;
    st_next.prevOt  = overTemp;

    // Dominant-time counter, restarted on each falling transmit edge
    if (!active || txdHigh)
    begin
      st_next.txCount = '0;
      st_next.timeout = 1'b0;
    end
    else if (st_reg.prevTxd)
      st_next.txCount = '0;
    else if (st_reg.txCount != TX_LIMIT)
      st_next.txCount = st_reg.txCount + 1'b1;
    else
      st_next.timeout = 1'b1;

    st_next.busOe = active && !txdHigh && !underVolt && !overTemp
                    && !st_next.timeout;
    st_next.rxd   = (active && !overTemp) ? busHigh : 1'b1;

    st_next.weakPu = !st_reg.ctrlMode;
    st_next.normPu = st_reg.ctrlMode;

    st_next.wakeEvt    = wakeBus.wakePulse;
    st_next.intPulse   = wakeBus.wakePulse && lowpowerRegulatorOn;
    st_next.regRestart = wakeBus.wakePulse && lowpowerRegulatorOff;

    if (wrCtrl)
    begin
      // Entering transmit/receive needs transmit high; sleep always accepted
      if (!regWdata[lin_pkg::CTRL_MODE_BIT] || txdHigh)
        st_next.ctrlMode = regWdata[lin_pkg::CTRL_MODE_BIT];
      unique case (regWdata[lin_pkg::CTRL_RATE_LSB +: 2])
        2'h1:    st_next.rate = lin_pkg::RATE_10K;
        2'h2:    st_next.rate = lin_pkg::RATE_FAST;
        default: st_next.rate = lin_pkg::RATE_20K;
      endcase
      st_next.wakeEn = regWdata[lin_pkg::CTRL_WAKEN_BIT];
    end
    if (regWrite && regAddr == lin_pkg::IRQ_EN_OFS)
      st_next.irqEn = regWdata[lin_pkg::IRQ_W-1:0];
    if (regWrite && regAddr == lin_pkg::IRQ_CLR_OFS)
      clr = regWdata[lin_pkg::IRQ_W-1:0];

    events[lin_pkg::IRQ_TOUT_BIT] = st_next.timeout && !st_reg.timeout;
    events[lin_pkg::IRQ_WAKE_BIT] = wakeBus.wakePulse;
    events[lin_pkg::IRQ_UV_BIT]   = underVolt && !st_reg.prevUv;
    events[lin_pkg::IRQ_OT_BIT]   = overTemp && !st_reg.prevOt;
    // A new event wins over a clear in the same cycle
    st_next.irqStat = (st_reg.irqStat & ~clr) | events;
    st_next.irqOut  = |(st_next.irqStat & st_next.irqEn);

    st_next.rdata = '0;
    if (regRead)
    begin
      unique case (regAddr)
        lin_pkg::CTRL_OFS:
          st_next.rdata = {4'h0, st_reg.wakeEn, st_reg.rate, st_reg.ctrlMode};
        lin_pkg::STATUS_OFS:
          st_next.rdata = {2'h0, st_reg.busOe, busHigh, overTemp, underVolt,
                           st_reg.timeout, st_reg.ctrlMode};
        lin_pkg::IRQ_STAT_OFS:
          st_next.rdata = {4'h0, st_reg.irqStat};
        lin_pkg::IRQ_EN_OFS:
          st_next.rdata = {4'h0, st_reg.irqEn};
        default:
          st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg            <= '0;
      // Idle levels: transmit high, bus recessive, so no false wake edge
      st_reg.sync1      <= 4'h3;
      st_reg.sync2      <= 4'h3;
      st_reg.prevTxd    <= 1'b1;
      st_reg.ctrlMode   <= lin_pkg::CTRL_MODE_RST;
      st_reg.rate       <= lin_pkg::CTRL_RATE_RST;
      st_reg.wakeEn     <= lin_pkg::CTRL_WAKEN_RST;
      st_reg.irqEn      <= lin_pkg::IRQ_EN_RST;
      st_reg.rxd        <= 1'b1;
      st_reg.weakPu     <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign regRdata          = st_reg.rdata;
  assign secondLinRxOutput = st_reg.rxd;
  // Open-drain: the pin is only ever pulled low
  assign secondBusPinOut   = 1'b0;
  assign secondBusPinOe    = st_reg.busOe;
  assign weakPullupEn      = st_reg.weakPu;
  assign normalPullupEn    = st_reg.normPu;
  assign slewSelect        = st_reg.rate;
  assign wakeEvent         = st_reg.wakeEvt;
  assign wakeIntPulse      = st_reg.intPulse;
  assign regulatorRestart  = st_reg.regRestart;
  assign irq               = st_reg.irqOut;

  AST_UV_RECESSIVE:
    assert property (@(posedge clock) disable iff (!resetn)
      underVolt |=> !secondBusPinOe)
    else $error("bus driven during supply undervoltage");

  AST_INACTIVE:
    assert property (@(posedge clock) disable iff (!resetn)
      !normalMode |=> !secondBusPinOe && secondLinRxOutput)
    else $error("transceiver active outside Normal mode");

  AST_RATE_SELECT:
    assert property (@(posedge clock) disable iff (!resetn)
      (regWrite && regAddr == lin_pkg::CTRL_OFS && regWdata[2:1] == 2'h2)
      |=> slewSelect == lin_pkg::RATE_FAST ##1 1'b1)
    else $error("fast rate not applied");

  AST_THERMAL:
    assert property (@(posedge clock) disable iff (!resetn)
      overTemp |=> !secondBusPinOe && secondLinRxOutput)
    else $error("transceiver enabled during overtemperature");

  AST_DOMINANT:
    assert property (@(posedge clock) disable iff (!resetn)
      (active && !txdHigh && !underVolt && !overTemp && st_reg.txCount == '0 && !st_reg.timeout)
      |=> secondBusPinOe)
    else $error("low transmit input did not drive dominant");

  AST_TIMEOUT_FLAG:
    assert property (@(posedge clock) disable iff (!resetn)
      $rose(st_reg.timeout) |-> st_reg.irqStat[lin_pkg::IRQ_TOUT_BIT] && !secondBusPinOe)
    else $error("timeout did not release bus or set flag");

  AST_RX_FOLLOWS:
    assert property (@(posedge clock) disable iff (!resetn)
      (active && !overTemp) |=> secondLinRxOutput == $past(busHigh))
    else $error("receive output does not follow bus");

  AST_TXRX_IGNORED:
    assert property (@(posedge clock) disable iff (!resetn)
      (regWrite && regAddr == lin_pkg::CTRL_OFS && regWdata[0] && !txdHigh && !st_reg.ctrlMode)
      |=> !st_reg.ctrlMode)
    else $error("mode command accepted while transmit low");

  AST_SLEEP_PULLUP:
    assert property (@(posedge clock) disable iff (!resetn)
      !st_reg.ctrlMode |=> weakPullupEn && !normalPullupEn)
    else $error("pull-up selection wrong in sleep");

  AST_WAKE_REPORT:
    assert property (@(posedge clock) disable iff (!resetn)
      wakeBus.wakePulse |=> wakeEvent && (wakeIntPulse == $past(lowpowerRegulatorOn))
      && (regulatorRestart == $past(lowpowerRegulatorOff)))
    else $error("wake-up not reported as required");
endmodule : lin_transceiver_control

// file: rtl/lin_wake_detect.sv
// Bus wake-up pattern detector: falling edge, long dominant, rising edge.
// Assumes a bus level already synchronised to clock.
`timescale 1ns/1ns
module lin_wake_detect
(
  input  wire logic clock,
  input  wire logic resetn,
  lin_wake_if.det   wk
);
  typedef enum logic [2:0] {
    W_IDLE  = 3'h1,
    W_LOW   = 3'h2,
    W_ARMED = 3'h4
  } wake_state_t;

  typedef struct packed {
    wake_state_t                      state;
    logic                             prevDom;
    logic [lin_pkg::WAKE_CNT_W-1:0]   count;
    logic                             pulse;
  } wake_t;

  wake_t st_reg;
  wake_t st_next;

  always_comb
  begin
    st_next         = st_reg;
    st_next.prevDom = wk.busDominant;
    st_next.pulse   = 1'b0;
    if (!wk.enable)
    begin
      st_next.state = W_IDLE;
    end
    else
    begin
      unique case (st_reg.state)
        W_IDLE:
        begin
          if (wk.busDominant && !st_reg.prevDom)
          begin
            st_next.state = W_LOW;
            st_next.count = '0;
          end
        end
        W_LOW:
        begin
          if (!wk.busDominant)
            st_next.state = W_IDLE;
          else if (st_reg.count == lin_pkg::WAKE_MIN_CYCLES[lin_pkg::WAKE_CNT_W-1:0])
            st_next.state = W_ARMED;
          else
            st_next.count = st_reg.count + 1'b1;
        end
        W_ARMED:
        begin
          if (!wk.busDominant)
          begin
            st_next.state = W_IDLE;
            st_next.pulse = 1'b1;
          end
        end
        default:
          st_next.state = W_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '{state: W_IDLE, prevDom: 1'b0, count: '0, pulse: 1'b0};
    else
      st_reg <= st_next;
  end

  assign wk.wakePulse = st_reg.pulse;

  AST_WAKE_SHAPE:
    assert property (@(posedge clock) disable iff (!resetn)
      wk.wakePulse |-> $past(st_reg.state == W_ARMED) && !$past(wk.busDominant))
    else $error("wake pulse without a full dominant pattern");

  AST_WAKE_GATED:
    assert property (@(posedge clock) disable iff (!resetn)
      wk.wakePulse |-> $past(wk.enable))
    else $error("wake pulse while detection disabled");

  AST_WAKE_RESTART:
    assert property (@(posedge clock) disable iff (!resetn)
      (st_reg.state == W_IDLE && wk.enable && wk.busDominant && !st_reg.prevDom)
      |=> st_reg.state == W_LOW && st_reg.count == '0)
    else $error("dominant count not restarted on falling edge");
endmodule : lin_wake_detect

// file: sim/lin_bus_model.sv
// Far side of the LIN pin: the pulled-up wire and one remote node.
// Assumes the block splits its open-drain pin into level, out and enable.
`timescale 1ns/1ns
module lin_bus_model
(
  input  wire logic dutOut,
  input  wire logic dutOe,
  input  wire logic remoteDominant,
  output logic      busLevel
);
  // Pull-up brings the wire recessive once every node lets go
  assign busLevel = !((dutOe && !dutOut) || remoteDominant);
endmodule : lin_bus_model

// file: sim/tb_lin_transceiver_control.sv
// Directed bench for the LIN transceiver control, using register tasks.
// Assumes the bus model on the pin and a 50 MHz clock.
`timescale 1ns/1ns
module tb_lin_transceiver_control;
  // Short timeout keeps the run brief
  localparam int TXDOM = 20;
  logic       clock;
  logic       resetn;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdata;
  logic       normalMode;
  logic       regOn;
  logic       regOff;
  logic       txd;
  logic       rxd;
  logic       busLevel;
  logic       pinOut;
  logic       pinOe;
  logic       uv;
  logic       ot;
  logic       remote;
  logic       weakPullupEn;
  logic       normalPullupEn;
  logic [1:0] slewSelect;
  logic       wakeEvent;
  logic       wakeIntPulse;
  logic       regulatorRestart;
  logic       irq;
  int         errors;
  int         numChecks;
  int         wakeCount;
  int         intCount;
  int         restartCount;

  lin_transceiver_control #(.TXDOM_CYCLES(TXDOM)) dut_u
  (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .normalMode(normalMode), .lowpowerRegulatorOn(regOn), .lowpowerRegulatorOff(regOff),
    .secondLinTxInput(txd), .secondLinRxOutput(rxd), .secondBusPinIn(busLevel),
    .secondBusPinOut(pinOut), .secondBusPinOe(pinOe), .supplyUndervoltage(uv),
    .driverOvertemp(ot), .weakPullupEn(weakPullupEn), .normalPullupEn(normalPullupEn),
    .slewSelect(slewSelect), .wakeEvent(wakeEvent), .wakeIntPulse(wakeIntPulse),
    .regulatorRestart(regulatorRestart), .irq(irq)
  );

  lin_bus_model bus_u (.dutOut(pinOut), .dutOe(pinOe), .remoteDominant(remote), .busLevel(busLevel));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Pulses stand one cycle, so count them at every edge
  always @(posedge clock)
  begin
    if (wakeEvent === 1'b1) wakeCount++;
    if (wakeIntPulse === 1'b1) intCount++;
    if (regulatorRestart === 1'b1) restartCount++;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expVal);
    numChecks++;
    if (seen !== expVal)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, expVal, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : write_reg

  task automatic read_check(input string name, input logic [7:0] a, input logic [7:0] expVal);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check(name, regRdata, expVal);
  endtask : read_check

  task automatic bus_pulse(input int n);
    @(posedge clock);
    remote <= 1'b1;
    repeat (n) @(posedge clock);
    remote <= 1'b0;
    step(10);
  endtask : bus_pulse

  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    give_verdict();
  end

  initial
  begin
    {resetn, regWrite, regRead, normalMode, regOn, regOff, uv, ot, remote} = '0;
    {regAddr, regWdata} = '0;
    {wakeCount, intCount, restartCount, errors, numChecks} = '0;
    txd = 1'b1;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    step(1);
    check("oe", 8'(pinOe), 8'h00);
    check("rxd", 8'(rxd), 8'h01);
    check("weak", 8'(weakPullupEn), 8'h01);
    check("normal", 8'(normalPullupEn), 8'h00);
    read_check("ctrl", lin_pkg::CTRL_OFS, 8'h08);
    read_check("unmapped", 8'h14, 8'h00);
    // Wake-up patterns, all in sleep
    write_reg(lin_pkg::CTRL_OFS, 8'h00);
    bus_pulse(3600);
    check("wake off", 8'(wakeCount), 8'h00);
    write_reg(lin_pkg::CTRL_OFS, 8'h08);
    bus_pulse(3000);
    check("short", 8'(wakeCount), 8'h00);
    @(posedge clock) regOn <= 1'b1;
    bus_pulse(3600);
    check("wake", 8'(wakeCount), 8'h01);
    check("int", 8'(intCount), 8'h01);
    check("restart", 8'(restartCount), 8'h00);
    read_check("irqstat", lin_pkg::IRQ_STAT_OFS, 8'h02);
    @(posedge clock) {regOn, regOff} <= 2'b01;
    bus_pulse(3600);
    check("int", 8'(intCount), 8'h01);
    check("restart", 8'(restartCount), 8'h01);
    check("irq", 8'(irq), 8'h00);
    write_reg(lin_pkg::IRQ_CLR_OFS, 8'h0F);
    read_check("irqstat", lin_pkg::IRQ_STAT_OFS, 8'h00);
    @(posedge clock) regOff <= 1'b0;
    // Rate codes; 3 is not a legal rate
    for (int r = 0; r < 4; r++)
    begin
      write_reg(lin_pkg::CTRL_OFS, 8'h08 | 8'(r << 1));
      step(2);
      check("slew", 8'(slewSelect), (r == 3) ? 8'h00 : 8'(r));
    end
    // Mode command while transmit is low must be dropped
    @(posedge clock) txd <= 1'b0;
    step(4);
    write_reg(lin_pkg::CTRL_OFS, 8'h09);
    read_check("ctrl", lin_pkg::CTRL_OFS, 8'h08);
    @(posedge clock) txd <= 1'b1;
    step(4);
    write_reg(lin_pkg::CTRL_OFS, 8'h09);
    read_check("ctrl", lin_pkg::CTRL_OFS, 8'h09);
    check("normal", 8'(normalPullupEn), 8'h01);
    check("weak", 8'(weakPullupEn), 8'h00);
    // Device not in Normal mode
    @(posedge clock) {txd, remote} <= 2'b01;
    step(5);
    check("oe", 8'(pinOe), 8'h00);
    check("rxd", 8'(rxd), 8'h01);
    @(posedge clock) {txd, remote} <= 2'b10;
    @(posedge clock) normalMode <= 1'b1;
    step(5);
    check("rxd", 8'(rxd), 8'h01);
    @(posedge clock) txd <= 1'b0;
    // Own dominant needs two more edges through the bus synchroniser
    step(6);
    check("oe", 8'(pinOe), 8'h01);
    check("rxd", 8'(rxd), 8'h00);
    step(30);
    check("oe", 8'(pinOe), 8'h00);
    read_check("status", lin_pkg::STATUS_OFS, 8'h13);
    write_reg(lin_pkg::IRQ_EN_OFS, 8'h01);
    step(2);
    check("irq", 8'(irq), 8'h01);
    @(posedge clock) txd <= 1'b1;
    step(5);
    read_check("status", lin_pkg::STATUS_OFS, 8'h11);
    write_reg(lin_pkg::IRQ_CLR_OFS, 8'h01);
    step(2);
    check("irq", 8'(irq), 8'h00);
    // Undervoltage, then overtemperature
    @(posedge clock) uv <= 1'b1;
    step(5);
    @(posedge clock) txd <= 1'b0;
    step(5);
    check("oe", 8'(pinOe), 8'h00);
    @(posedge clock) uv <= 1'b0;
    step(5);
    check("oe", 8'(pinOe), 8'h01);
    @(posedge clock) {txd, ot, remote} <= 3'b111;
    step(5);
    check("rxd", 8'(rxd), 8'h01);
    @(posedge clock) txd <= 1'b0;
    step(5);
    check("oe", 8'(pinOe), 8'h00);
    @(posedge clock) ot <= 1'b0;
    step(5);
    check("oe", 8'(pinOe), 8'h01);
    check("rxd", 8'(rxd), 8'h00);
    @(posedge clock) {txd, remote} <= 2'b10;
    step(5);
    read_check("irqstat", lin_pkg::IRQ_STAT_OFS, 8'h0C);
    // Back to sleep: transmit path off
    write_reg(lin_pkg::CTRL_OFS, 8'h08);
    @(posedge clock) txd <= 1'b0;
    step(5);
    check("oe", 8'(pinOe), 8'h00);
    check("weak", 8'(weakPullupEn), 8'h01);
    @(posedge clock) txd <= 1'b1;
    step(2);
    give_verdict();
  end
endmodule : tb_lin_transceiver_control
